// ==== hw/qtimer_pkg.sv ====
// Purpose: constants shared by the quadrature timer group
// Assumes: 16-bit registers on a plain strobe port, 25 MHz clock
// Notes: control word layout is common to all three timers
// What this block does
// RL1 - Modes 110 and 111 select quadrature
// RL2 - Count every chosen edge: 2x or 4x
// RL3 - Edge select picks line a, b, both
// RL4 - Quadrature interrupt only when enabled
// RL5 - Mode 110 interrupts on direction change
// RL6 - Mode 111 interrupts on every count
// RL7 - Direction, change and count flags readable
// RL8 - Direction derived from edge and other line
// RL9 - Software sets direction enable, pins input
// RL10 - Encoder below clk/8, levels hold four cycles
// RL11 - Aux run bit, or core run when remote
// RL12 - Aux b edge select: input or toggle
// RL13 - Software toggle writes never count
// RL14 - Aux a counts only toggle transitions
// RL15 - Aux b input below clk/8, four-cycle levels
// RL16 - Both toggle edges give 32-bit chain
// RL17 - One toggle edge gives 33-bit chain
// RL18 - Chained timers keep own directions
// RL19 - Aux timers lack toggle latch and output
// RL20 - Aux a adds quadrature, aux b not
// RL21 - Common fields share bit positions everywhere
// RL22 - Core wrap toggles latch, software may write
// RL23 - Software write beats pending count
// RL24 - Timers wrap ffff to 0 and back
package qtimer_pkg;
    localparam int ADDR_W = 3;                  // Register index width
    localparam int DATA_W = 16;                 // Register width
    // Register offsets
    localparam logic [2:0] OFS_CORE_CTL = 3'h0;
    localparam logic [2:0] OFS_AUXA_CTL = 3'h1;
    localparam logic [2:0] OFS_AUXB_CTL = 3'h2;
    localparam logic [2:0] OFS_CORE_CNT = 3'h3;
    localparam logic [2:0] OFS_AUXA_CNT = 3'h4;
    localparam logic [2:0] OFS_AUXB_CNT = 3'h5;
    // Field positions, same in every control word
    localparam int F_ISEL = 0;                  // Edge select, 3 bits
    localparam int F_MODE = 3;                  // Mode field, 3 bits
    localparam int F_RUN  = 6;                  // Run bit
    localparam int F_UD   = 7;                  // Software down bit
    localparam int F_UDE  = 8;                  // External direction enable
    localparam int F_TOG  = 9;                  // Core toggle / aux remote run
    localparam int F_OE   = 10;                 // Toggle output enable
    localparam int F_IREN = 11;                 // Quadrature interrupt enable
    localparam int F_RDIR = 12;                 // Direction status, 1 = down
    localparam int F_CHG  = 13;                 // Direction change flag
    localparam int F_EDGE = 14;                 // Count edge flag
    // Reset values and write masks
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] CORE_WMASK = 16'h6fff;
    localparam logic [15:0] AUX_WMASK = 16'h03ff;
    // Mode codes
    localparam logic [2:0] M_TIMER   = 3'h0;
    localparam logic [2:0] M_COUNTER = 3'h1;
    localparam logic [2:0] M_GATE_LO = 3'h2;
    localparam logic [2:0] M_GATE_HI = 3'h3;
    localparam logic [2:0] M_QUAD_ROT  = 3'h6;
    localparam logic [2:0] M_QUAD_EDGE = 3'h7;
    // Prescaler: timer rate is clk / (8 * 2^select)
    localparam int PRE_BASE = 3;
    localparam int PRE_W = 10;
endpackage

// ==== hw/edge_detect.sv ====
// Purpose: rise and fall pulses for synchronous input lines
// Assumes: inputs already synchronous to clk
// Notes: first cycle after reset sees a high line as a rise
`timescale 1ns/100ps
module edge_detect #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] lvl_in,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] prev;             // Level one cycle ago
    } ed_st_t;
    ed_st_t s_r;
    ed_st_t s_nxt;

    if (W < 1) begin : g_chk
        $error("edge_detect needs W >= 1");
    end

    // Next state and pulses
    always_comb begin
        s_nxt.prev = lvl_in;
        rise = lvl_in & ~s_r.prev;
        fall = ~lvl_in & s_r.prev;
    end

    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// ==== hw/timer16.sv ====
// Purpose: one up/down counter with load and wrap pulse
// Assumes: load and step are single-cycle qualifiers
// Notes: a load in the step cycle wins and suppresses the wrap
`timescale 1ns/100ps
module timer16 #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         ld,
    input  wire logic [W-1:0] ld_val,
    input  wire logic         step,
    input  wire logic         up,
    output logic      [W-1:0] value,
    output logic              wrap
);
    typedef struct packed {
        logic [W-1:0] cnt;              // Count value
    } tm_st_t;
    tm_st_t s_r;
    tm_st_t s_nxt;

    if (W < 2) begin : g_chk
        $error("timer16 needs W >= 2");
    end

    // RL24 roll-over wrap pulse
    // Load beats count, so a written value never wraps
    always_comb begin
        s_nxt = s_r;
        wrap = 1'b0;
        if (ld) begin
            s_nxt.cnt = ld_val;
        end else if (step) begin
            wrap = up ? (&s_r.cnt) : (s_r.cnt == '0);
            s_nxt.cnt = up ? s_r.cnt + 1'b1 : s_r.cnt - 1'b1;
        end
        value = s_r.cnt;
    end

    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// ==== hw/quadrature_timer_block.sv ====
// Purpose: core timer with quadrature mode and two auxiliary timers
// Assumes: register port strobes one cycle, inputs synchronous
// Notes: reload and capture modes of the aux timers are not built
`timescale 1ns/100ps
module quadrature_timer_block (
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire logic [qtimer_pkg::ADDR_W-1:0] addr,
    input  wire logic [qtimer_pkg::DATA_W-1:0] wdata,
    input  wire logic                          wr_stb,
    input  wire logic                          rd_stb,
    output logic      [qtimer_pkg::DATA_W-1:0] rdata,
    input  wire logic                          encoder_line_a,
    input  wire logic                          encoder_line_b,
    input  wire logic                          aux_b_count_input,
    input  wire logic                          aux_a_direction_input,
    output logic                               toggle_output_line,
    output logic                               quad_irq
);
    import qtimer_pkg::*;

    // Whole block state
    typedef struct packed {
        logic [15:0]      cctl;         // Core control and status
        logic [15:0]      actl;         // Aux a control
        logic [15:0]      bctl;         // Aux b control
        logic [PRE_W-1:0] pre;          // Free-running prescaler
        logic [15:0]      rd;           // Read data, one cycle
        logic             tout;         // Toggle output line
        logic             irq;          // Interrupt request pulse
    } blk_st_t;
    blk_st_t s_r;
    blk_st_t s_nxt;

    // Edge pulses: 0 line a, 1 line b, 2 aux b input, 3 aux a dir
    logic [3:0]  rise;
    logic [3:0]  fall;
    // Per-timer hooks: 0 core, 1 aux a, 2 aux b
    logic [2:0]  ld;
    logic [2:0]  step;
    logic [2:0]  up;
    logic [2:0]  wrap;
    logic [15:0] val [3];

    // Timer tick: low prescaler bits all ones
    function automatic logic pre_tick(input logic [PRE_W-1:0] p,
                                      input logic [2:0] sel);
        logic [PRE_W:0] m;
        m = ({{PRE_W{1'b0}}, 1'b1} << (PRE_BASE + int'(sel))) - 1'b1;
        return (p & m[PRE_W-1:0]) == m[PRE_W-1:0];
    endfunction

    // Counter-mode edge match on select low bits
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic r,
                                      input logic f);
        return (sel[0] & r) | (sel[1] & f);
    endfunction

    // Plain direction: software bit, xor external line when enabled, 1 = down
    function automatic logic dir_down(input logic [15:0] c,
                                      input logic line);
        return c[F_UDE] ? (c[F_UD] ^ line) : c[F_UD];
    endfunction

    edge_detect #(
        .W (4)
    ) u_edge (
        .clk     (clk),
        .reset_n (reset_n),
        .lvl_in  ({aux_a_direction_input, aux_b_count_input,
                   encoder_line_b, encoder_line_a}),
        .rise    (rise),
        .fall    (fall)
    );

    // One counter per timer, loads from the register port
    for (genvar i = 0; i < 3; i++) begin : g_tmr
        timer16 #(
            .W (16)
        ) u_tmr (
            .clk     (clk),
            .reset_n (reset_n),
            .ld      (ld[i]),
            .ld_val  (wdata),
            .step    (step[i]),
            .up      (up[i]),
            .value   (val[i]),
            .wrap    (wrap[i])
        );
    end

    // Decoded control fields
    logic [2:0] c_mode;
    logic [2:0] c_sel;
    logic [2:0] a_mode;
    logic [2:0] a_sel;
    logic [2:0] b_mode;
    logic [2:0] b_sel;
    logic       c_quad;          // Core in quadrature mode
    logic       a_run;           // Effective aux a run
    logic       b_run;           // Effective aux b run
    logic       cctl_wr;         // Core control written
    logic       qa;              // Qualified line a edge
    logic       qb;              // Qualified line b edge
    logic       qdn;             // Derived direction, 1 = down
    logic       qev;             // Quadrature count action
    logic       tog_hw;          // Wrap-caused toggle transition
    logic       tog_rise;        // Toggle rising, hardware only
    logic       tog_fall;        // Toggle falling, hardware only
    logic       a_qdn;           // Aux a quadrature direction

    always_comb begin
        c_mode = s_r.cctl[F_MODE +: 3];
        c_sel  = s_r.cctl[F_ISEL +: 3];
        a_mode = s_r.actl[F_MODE +: 3];
        a_sel  = s_r.actl[F_ISEL +: 3];
        b_mode = s_r.bctl[F_MODE +: 3];
        b_sel  = s_r.bctl[F_ISEL +: 3];
        cctl_wr = wr_stb && (addr == OFS_CORE_CTL);
        ld[0] = wr_stb && (addr == OFS_CORE_CNT);
        ld[1] = wr_stb && (addr == OFS_AUXA_CNT);
        ld[2] = wr_stb && (addr == OFS_AUXB_CNT);
    end

    // RL1 RL3 quadrature edge qualification
    always_comb begin
        c_quad = (c_mode == M_QUAD_ROT) || (c_mode == M_QUAD_EDGE);
        // Reserved selects with top bit set count nothing
        qa = c_quad && !c_sel[2] && c_sel[0] && (rise[0] || fall[0]);
        qb = c_quad && !c_sel[2] && c_sel[1] && (rise[1] || fall[1]);
    end

    // RL8 direction from edge and other line level
    always_comb begin
        if (qa) begin
            qdn = rise[0] ? encoder_line_b : !encoder_line_b;
        end else if (qb) begin
            qdn = rise[1] ? !encoder_line_a : encoder_line_a;
        end else begin
            qdn = s_r.cctl[F_RDIR];
        end
    end

    // Core timer stepping per mode
    always_comb begin
        unique case (c_mode)
            M_TIMER: begin
                step[0] = pre_tick(s_r.pre, c_sel);
            end
            M_GATE_LO: begin
                step[0] = pre_tick(s_r.pre, c_sel) && !encoder_line_a;
            end
            M_GATE_HI: begin
                step[0] = pre_tick(s_r.pre, c_sel) && encoder_line_a;
            end
            M_COUNTER: begin
                step[0] = !c_sel[2] && edge_hit(c_sel[1:0], rise[0], fall[0]);
            end
            // RL2 one count per qualified transition
            M_QUAD_ROT, M_QUAD_EDGE: begin
                step[0] = qa || qb;
            end
            // Reload and capture codes are not served here
            default: begin
                step[0] = 1'b0;
            end
        endcase
        step[0] = step[0] && s_r.cctl[F_RUN];
        up[0] = c_quad ? !qdn : !dir_down(s_r.cctl, encoder_line_b);
        // RL23 a count lost to a register write raises nothing
        qev = c_quad && step[0] && !ld[0];
    end

    // RL13 RL22 toggle edges only from hardware wraps
    always_comb begin
        tog_hw = wrap[0] && !cctl_wr;
        tog_rise = tog_hw && !s_r.cctl[F_TOG];
        tog_fall = tog_hw && s_r.cctl[F_TOG];
    end

    // RL11 remote run follows the core run bit
    always_comb begin
        a_run = s_r.actl[F_TOG] ? s_r.cctl[F_RUN] : s_r.actl[F_RUN];
        b_run = s_r.bctl[F_TOG] ? s_r.cctl[F_RUN] : s_r.bctl[F_RUN];
    end

    // Aux a: no count pin, input taken as low
    always_comb begin
        a_qdn = rise[3];
        unique case (a_mode)
            // RL19 timer behaviour as the core, no latch
            M_TIMER, M_GATE_LO: begin
                step[1] = pre_tick(s_r.pre, a_sel);
            end
            M_GATE_HI: begin
                step[1] = 1'b0;
            end
            // RL14 RL16 RL17 toggle-driven chaining
            M_COUNTER: begin
                step[1] = a_sel[2] && edge_hit(a_sel[1:0], tog_rise, tog_fall);
            end
            // RL20 quadrature on the direction line alone
            M_QUAD_ROT, M_QUAD_EDGE: begin
                step[1] = !a_sel[2] && a_sel[1] && (rise[3] || fall[3]);
            end
            default: begin
                step[1] = 1'b0;
            end
        endcase
        step[1] = step[1] && a_run;
        // RL18 own direction, independent of the core
        if (a_mode[2:1] == 2'b11) begin
            up[1] = !a_qdn;
        end else begin
            up[1] = !dir_down(s_r.actl, aux_a_direction_input);
        end
    end

    // Aux b: timer, gated and counter modes only
    always_comb begin
        unique case (b_mode)
            M_TIMER: begin
                step[2] = pre_tick(s_r.pre, b_sel);
            end
            M_GATE_LO: begin
                step[2] = pre_tick(s_r.pre, b_sel) && !aux_b_count_input;
            end
            M_GATE_HI: begin
                step[2] = pre_tick(s_r.pre, b_sel) && aux_b_count_input;
            end
            // RL12 input pin or toggle latch edges
            M_COUNTER: begin
                if (b_sel[2]) begin
                    step[2] = edge_hit(b_sel[1:0], tog_rise, tog_fall);
                end else begin
                    step[2] = edge_hit(b_sel[1:0], rise[2], fall[2]);
                end
            end
            default: begin
                step[2] = 1'b0;
            end
        endcase
        step[2] = step[2] && b_run;
        up[2] = !dir_down(s_r.bctl, 1'b0);
    end

    // Control registers, status flags, read port
    always_comb begin
        s_nxt = s_r;
        s_nxt.pre = s_r.pre + 1'b1;
        // RL21 RL22 software writes, status direction kept
        if (cctl_wr) begin
            s_nxt.cctl = wdata & CORE_WMASK;
            s_nxt.cctl[F_RDIR] = s_r.cctl[F_RDIR];
        end
        if (wr_stb && (addr == OFS_AUXA_CTL)) begin
            s_nxt.actl = wdata & AUX_WMASK;
        end
        if (wr_stb && (addr == OFS_AUXB_CTL)) begin
            s_nxt.bctl = wdata & AUX_WMASK;
        end
        // RL22 each wrap flips the latch, except in a core control write cycle
        if (tog_hw) begin
            s_nxt.cctl[F_TOG] = !s_r.cctl[F_TOG];
        end
        // RL7 flags set after the write, so set wins
        if (qev) begin
            s_nxt.cctl[F_RDIR] = qdn;
            s_nxt.cctl[F_EDGE] = 1'b1;
            if (qdn != s_r.cctl[F_RDIR]) begin
                s_nxt.cctl[F_CHG] = 1'b1;
            end
        end
        // RL4 RL5 RL6 interrupt by variant when enabled
        s_nxt.irq = qev && s_r.cctl[F_IREN] &&
                    ((c_mode == M_QUAD_EDGE) || (qdn != s_r.cctl[F_RDIR]));
        s_nxt.tout = s_nxt.cctl[F_TOG] && s_nxt.cctl[F_OE];
        // Read data valid only in the cycle after the strobe
        s_nxt.rd = '0;
        if (rd_stb) begin
            unique case (addr)
                OFS_CORE_CTL: s_nxt.rd = s_r.cctl;
                OFS_AUXA_CTL: s_nxt.rd = s_r.actl;
                OFS_AUXB_CTL: s_nxt.rd = s_r.bctl;
                OFS_CORE_CNT: s_nxt.rd = val[0];
                OFS_AUXA_CNT: s_nxt.rd = val[1];
                OFS_AUXB_CNT: s_nxt.rd = val[2];
                // Unmapped offsets read zero
                default: s_nxt.rd = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '{cctl: CTL_RESET, actl: CTL_RESET, bctl: CTL_RESET,
                     default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flops
    always_comb begin
        rdata = s_r.rd;
        toggle_output_line = s_r.tout;
        quad_irq = s_r.irq;
    end

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_quad_sel_off: assert property ( // RL3
        (c_quad && c_sel == 3'h0) |-> !step[0])
        else $error("quadrature counted with select off");
    a_irq_needs_en: assert property ( // RL4
        quad_irq |-> $past(s_r.cctl[F_IREN]))
        else $error("interrupt without enable");
    a_rot_irq_chg: assert property ( // RL5
        (qev && c_mode == M_QUAD_ROT && s_r.cctl[F_IREN] &&
         qdn != s_r.cctl[F_RDIR]) |=> quad_irq ##1 !quad_irq)
        else $error("rotation interrupt missing");
    a_edge_irq_cnt: assert property ( // RL6
        (qev && c_mode == M_QUAD_EDGE && s_r.cctl[F_IREN]) |=> quad_irq)
        else $error("edge interrupt missing");
    a_edge_flag_set: assert property ( // RL7
        qev |=> s_r.cctl[F_EDGE] && s_r.cctl[F_RDIR] == !$past(up[0]))
        else $error("count flag or direction wrong");
    a_dir_a_rise: assert property ( // RL8
        (qa && rise[0] && encoder_line_b && s_r.cctl[F_RUN] && !ld[0])
        |=> s_r.cctl[F_RDIR])
        else $error("line a rise with b high must count down");
    a_remote_stop: assert property ( // RL11
        (s_r.actl[F_TOG] && !s_r.cctl[F_RUN]) |-> !step[1])
        else $error("remote aux a ran with core stopped");
    a_sw_tog_nocount: assert property ( // RL13
        (cctl_wr && b_mode == M_COUNTER && b_sel[2]) |-> !step[2])
        else $error("software toggle write counted");
    a_core_tog_flip: assert property ( // RL22
        tog_hw |=> s_r.cctl[F_TOG] != $past(s_r.cctl[F_TOG]))
        else $error("wrap did not flip toggle");
    a_write_wins: assert property ( // RL23
        ld[0] |=> val[0] == $past(wdata))
        else $error("count beat register write");
    a_wrap_up: assert property ( // RL24
        (step[0] && up[0] && !ld[0] && val[0] == 16'hffff) |=> val[0] == 16'h0000)
        else $error("up wrap wrong");

    c_quad_count: cover property (qev ##[1:20] qev);
    c_dir_change: cover property (quad_irq && c_mode == M_QUAD_ROT);
    c_chain_b: cover property (tog_hw && step[2]);
    c_chain_a: cover property (tog_rise && step[1]);
endmodule

// ==== test/encoder_model.sv ====
// Purpose: incremental position encoder driving the two quadrature lines
// Assumes: one step per call, lines start low after reset
// Notes: holds every level nine clocks, the fastest legal encoder rate
`timescale 1ns/100ps
module encoder_model (
    input  wire logic clk,
    input  wire logic reset_n,
    output logic      encoder_line_a,
    output logic      encoder_line_b
);
    logic [1:0] phase_r;                    // Position within one encoder cycle

    // gray sequence, down order
    // Pattern {a,b}: 00, 01, 11, 10 when stepping down
    always_comb begin
        encoder_line_a = phase_r[1];
        encoder_line_b = phase_r[1] ^ phase_r[0];
    end

    // Phase starts at 00 so no edge is seen at reset release
    initial begin
        phase_r = 2'h0;
    end

    // level hold time
    // Nine clocks per step keeps the rate at clk/9 and levels above four clocks
    task automatic step(input logic down);
        @(posedge clk);
        phase_r <= down ? phase_r + 2'h1 : phase_r - 2'h1;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ==== test/quadrature_timer_block_bench.sv ====
// Purpose: self-checking bench for the quadrature timer group
// Assumes: register port per hand-over, encoder model on the core lines
// Notes: aux pins pulsed three times, otherwise toggle-latch counting is exercised
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module quadrature_timer_block_bench;
    import qtimer_pkg::*;
    logic        clk, reset_n, wr_stb, rd_stb;    // Clock, reset, strobes
    logic [2:0]  addr;                            // Register index
    logic [15:0] wdata, rdata, seen;              // Bus data, last read
    logic        line_a, line_b, tog_out, irq;    // Encoder lines, outputs
    logic        aux_b_in, aux_a_dir;             // Aux input pins
    int          errors, n_compared, irq_cnt, cycles;
    int          exp_n [5] = '{0, 2, 2, 4, 0};    // Counts per edge select

    quadrature_timer_block i_quadrature_timer_block (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .encoder_line_a(line_a),
        .encoder_line_b(line_b), .aux_b_count_input(aux_b_in),
        .aux_a_direction_input(aux_a_dir), .toggle_output_line(tog_out), .quad_irq(irq));

    encoder_model i_encoder_model (
        .clk(clk), .reset_n(reset_n), .encoder_line_a(line_a), .encoder_line_b(line_b));

    // Free-running 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Interrupt pulse counter and hang guard
    always @(posedge clk) begin
        cycles++;
        if (irq === 1'b1) irq_cnt++;
        if (cycles == 6000) begin
            errors++;
            finish_test();
        end
    end

    // Closing report and verdict
    task automatic finish_test();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    // Read strobe, data taken in the following cycle only
    task automatic chk_rd(input logic [2:0] a, input logic [15:0] e, input string nm);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(negedge clk);
        seen = rdata;
        `CHK(nm, e, seen)
    endtask

    // Several encoder steps in one direction
    task automatic steps(input int n, input logic down);
        repeat (n) i_encoder_model.step(down);
    endtask

    // Main sequence
    initial begin
        reset_n = 1'b0;
        addr = 3'h0;
        wdata = 16'h0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        aux_b_in = 1'b0;
        aux_a_dir = 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        // Reset values, unmapped indices included
        for (int a = 0; a < 8; a++) chk_rd(a[2:0], 16'h0000, "reset value");
        // Edge-variant quadrature, 4x, irq and toggle output enabled
        wr(OFS_CORE_CTL, 16'h0d7b);
        irq_cnt = 0;
        steps(4, 1'b1);
        chk_rd(OFS_CORE_CNT, 16'hfffc, "down count wrap");
        `CHK("irq per count", 4, irq_cnt)
        chk_rd(OFS_CORE_CTL, 16'h7f7b, "status flags");
        `CHK("toggle output", 1'b1, tog_out)
        steps(4, 1'b0);
        chk_rd(OFS_CORE_CNT, 16'h0000, "up count wrap");
        `CHK("toggle output off", 1'b0, tog_out)
        // Rotation variant: irq only on direction change
        wr(OFS_CORE_CTL, 16'h0973);
        irq_cnt = 0;
        steps(2, 1'b1);
        steps(2, 1'b0);
        `CHK("irq per reversal", 2, irq_cnt)
        // Interrupt enable cleared: no request
        wr(OFS_CORE_CTL, 16'h0173);
        irq_cnt = 0;
        steps(1, 1'b1);
        `CHK("irq disabled", 0, irq_cnt)
        // Edge select table, reserved code included
        for (int s = 0; s < 5; s++) begin
            wr(OFS_CORE_CTL, 16'h0178 | 16'(s));
            wr(OFS_CORE_CNT, 16'h0000);
            steps(4, 1'b1);
            chk_rd(OFS_CORE_CNT, 16'h0000 - 16'(exp_n[s]), "edge select");
        end
        // Chaining: aux b on both toggle edges, aux a remote-run on rise
        wr(OFS_AUXB_CTL, 16'h004f);
        wr(OFS_AUXA_CTL, 16'h020d);
        wr(OFS_AUXB_CNT, 16'h0000);
        wr(OFS_AUXA_CNT, 16'h0000);
        wr(OFS_CORE_CTL, 16'h037b);
        wr(OFS_CORE_CTL, 16'h017b);
        chk_rd(OFS_AUXB_CNT, 16'h0000, "software toggle");
        wr(OFS_CORE_CNT, 16'hfffd);
        steps(6, 1'b0);
        chk_rd(OFS_CORE_CNT, 16'h0003, "core overflow");
        chk_rd(OFS_AUXA_CNT, 16'h0001, "aux a rise");
        wr(OFS_CORE_CNT, 16'hffff);
        steps(1, 1'b0);
        chk_rd(OFS_AUXB_CNT, 16'h0002, "aux b chain");
        chk_rd(OFS_AUXA_CNT, 16'h0001, "aux a chain");
        // Aux b counts rises of its own pin, down; aux a line must not count
        wr(OFS_AUXB_CTL, 16'h00c9);
        wr(OFS_AUXB_CNT, 16'h0000);
        repeat (3) begin
            @(posedge clk);
            aux_b_in <= 1'b1;
            aux_a_dir <= 1'b1;
            repeat (8) @(posedge clk);
            aux_b_in <= 1'b0;
            aux_a_dir <= 1'b0;
            repeat (8) @(posedge clk);
        end
        chk_rd(OFS_AUXB_CNT, 16'hfffd, "aux b pin count");
        chk_rd(OFS_AUXA_CNT, 16'h0001, "aux a pin ignored");
        finish_test();
    end
endmodule
